// *** common/jti_map.svh ***
// Instruction codes, chain widths and field positions of the test port
`ifndef JTI_MAP_SVH
`define JTI_MAP_SVH
`define JTI_IR_W         4
`define JTI_IR_EXTEST    4'h0
`define JTI_IR_INTEST    4'h1
`define JTI_IR_SAMPLE    4'h2
`define JTI_IR_ABORT     4'h8
`define JTI_IR_DBG_PORT  4'hA
`define JTI_IR_ACC_PORT  4'hB
`define JTI_IR_IDCODE    4'hE
`define JTI_IR_BYPASS    4'hF
`define JTI_IR_CAPTURE   4'h1
`define JTI_ID_W         32
`define JTI_ACC_W        35
`define JTI_CELLS_PER_PIN 3
`define JTI_CELL_IN      0
`define JTI_CELL_OUT     1
`define JTI_CELL_OE      2
`define JTI_ABORT_BIT    3
`define JTI_STICKY_LO    4
`define JTI_STICKY_HI    7
`define JTI_BYP_CAPTURE  1'b0
`endif

// *** common/jti_pkg.sv ***
// Types shared by the test access port logic
package jti_pkg;
    typedef enum logic [3:0] {
        JTI_TLR     = 4'h0, JTI_RTI     = 4'h1, JTI_SEL_DR  = 4'h2, JTI_CAP_DR  = 4'h3,
        JTI_SH_DR   = 4'h4, JTI_EX1_DR  = 4'h5, JTI_PAU_DR  = 4'h6, JTI_EX2_DR  = 4'h7,
        JTI_UPD_DR  = 4'h8, JTI_SEL_IR  = 4'h9, JTI_CAP_IR  = 4'hA, JTI_SH_IR   = 4'hB,
        JTI_EX1_IR  = 4'hC, JTI_PAU_IR  = 4'hD, JTI_EX2_IR  = 4'hE, JTI_UPD_IR  = 4'hF
    } jti_state_t;
    typedef enum logic [2:0] {
        JTI_DR_BSR = 3'h0, JTI_DR_ABORT = 3'h1, JTI_DR_DP = 3'h2,
        JTI_DR_AP  = 3'h3, JTI_DR_ID    = 3'h4, JTI_DR_BYP = 3'h5
    } jti_dr_t;
    typedef enum logic [1:0] {
        JTI_ACC_ABORT = 2'h0, JTI_ACC_DP = 2'h1, JTI_ACC_AP = 2'h2
    } jti_acc_t;
endpackage

// *** design/jti_tap_regs.sv ***
// Test access port: instruction register, data chains, boundary scan and debug crossing
//
// Overview of operation
// - Four-bit instruction shift stage; takes effect only after the update stage.
// - Codes 0000, 0001, 0010 select boundary scan modes EXTEST, INTEST, SAMPLE.
// - Codes 1000, 1010, 1011 select abort, debug-port and access-port chains.
// - Code 1110 selects identification chain, 1111 selects single-bit bypass.
// - Every unassigned code acts as bypass, keeping a TDI to TDO path.
// - EXTEST drives pads from preloaded output and output-enable cells.
// - INTEST drives core inputs from preloaded input cells instead of pads.
// - Reset pin has an input-only cell, observed but never driven.
// - SAMPLE captures pad input, output and enable at Capture-DR.
// - Shift-DR moves data out and in; Update-DR loads holding registers.
// - Each pin gives cells input, output, enable, pins chained in order.
// - Identification instruction loads on power-on reset, TRST and Test-Logic-Reset.
// - Identification chain is 32 bits, LSB 1, constant code.
// - Bypass chain is one bit and captures 0.
// - Abort, debug-port and access-port chains are 35 bits each.
// - Abort chain data aborts requests or clears sticky errors.
// - Debug-port and access-port chains give read and write access.
// - No chain is on a processor bus; only serial access.
// - Power-on reset resets the port; external reset pin does not.
`include "jti_map.svh"

// Two-flop level synchroniser
module jti_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         arst,
    input  wire logic [W-1:0] d,
    output logic [W-1:0]      q
);
    logic [W-1:0] meta_reg;

    // First stage feeds only the second
    always_ff @(posedge clk or posedge arst) begin
        if (arst) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule // jti_sync

module jti_tap_regs #(
    parameter int          NPIN    = 8,
    parameter logic [31:0] ID_CODE = 32'h0A5C_3001   // Arbitrary identification value
) (
    // System clock and power-on reset
    input  wire logic                  clock,
    input  wire logic                  rst,
    // Test port
    input  wire logic                  tck,
    input  wire logic                  tms,
    input  wire logic                  tdi,
    input  wire logic                  trst_n,
    output logic                       tdo,
    output logic                       tdo_oe,
    // Pads
    input  wire logic [NPIN-1:0]       pad_in,
    input  wire logic                  ext_rst_n_pad,
    output logic [NPIN-1:0]            pad_out,
    output logic [NPIN-1:0]            pad_oe,
    // Core side of the pads
    input  wire logic [NPIN-1:0]       core_out,
    input  wire logic [NPIN-1:0]       core_oe,
    output logic [NPIN-1:0]            core_in,
    output logic                       core_ext_rst_n,
    // Debug access unit
    output logic                       dbg_req,
    output jti_pkg::jti_acc_t          dbg_sel,
    output logic [`JTI_ACC_W-1:0]      dbg_wdata,
    output logic                       dbg_abort,
    output logic                       dbg_clr_sticky,
    input  wire logic [`JTI_ACC_W-1:0] dbg_rdata
);
    import jti_pkg::*;

    localparam int BSR_W = `JTI_CELLS_PER_PIN * NPIN + 1;

    // Test clock domain state
    logic                  tap_arst, byp_reg, acc_tgl_reg, extest_reg, intest_reg;
    jti_state_t            state_reg, state_next;
    logic [`JTI_IR_W-1:0]  ir_shift_reg, ir_reg;
    jti_dr_t               dr_sel;
    logic [BSR_W-1:0]      bsr_shift_reg, bsr_upd_reg, sample_t;
    logic [`JTI_ID_W-1:0]  id_shift_reg;
    logic [`JTI_ACC_W-1:0] acc_shift_reg, acc_wd_reg, rdata_t;
    jti_acc_t              acc_sel_reg;
    // System clock domain state
    logic                  ext_rst_s, extest_s, intest_s, acc_tgl_s, acc_tgl_d_reg;
    logic [NPIN-1:0]       pad_in_s, upd_in, upd_out, upd_oe;
    logic [BSR_W-1:0]      bsr_upd_s, sample_reg;
    logic [`JTI_ACC_W-1:0] rdata_reg;

    // Power-on reset or TRST; the external reset pin is only a boundary cell
    assign tap_arst = rst | ~trst_n;

    // Sixteen-state controller, advanced by TMS on rising TCK
    always_comb begin
        unique case (state_reg)
            JTI_TLR:    state_next = tms ? JTI_TLR    : JTI_RTI;
            JTI_RTI:    state_next = tms ? JTI_SEL_DR : JTI_RTI;
            JTI_SEL_DR: state_next = tms ? JTI_SEL_IR : JTI_CAP_DR;
            JTI_CAP_DR: state_next = tms ? JTI_EX1_DR : JTI_SH_DR;
            JTI_SH_DR:  state_next = tms ? JTI_EX1_DR : JTI_SH_DR;
            JTI_EX1_DR: state_next = tms ? JTI_UPD_DR : JTI_PAU_DR;
            JTI_PAU_DR: state_next = tms ? JTI_EX2_DR : JTI_PAU_DR;
            JTI_EX2_DR: state_next = tms ? JTI_UPD_DR : JTI_SH_DR;
            JTI_UPD_DR: state_next = tms ? JTI_SEL_DR : JTI_RTI;
            JTI_SEL_IR: state_next = tms ? JTI_TLR    : JTI_CAP_IR;
            JTI_CAP_IR: state_next = tms ? JTI_EX1_IR : JTI_SH_IR;
            JTI_SH_IR:  state_next = tms ? JTI_EX1_IR : JTI_SH_IR;
            JTI_EX1_IR: state_next = tms ? JTI_UPD_IR : JTI_PAU_IR;
            JTI_PAU_IR: state_next = tms ? JTI_EX2_IR : JTI_PAU_IR;
            JTI_EX2_IR: state_next = tms ? JTI_UPD_IR : JTI_SH_IR;
            JTI_UPD_IR: state_next = tms ? JTI_SEL_DR : JTI_RTI;
        endcase
    end

    // Controller state register
    always_ff @(posedge tck or posedge tap_arst) begin
        if (tap_arst) begin
            state_reg <= JTI_TLR;
        end else begin
            state_reg <= state_next;
        end
    end

    // Instruction shift stage
    always_ff @(posedge tck or posedge tap_arst) begin
        if (tap_arst) begin
            ir_shift_reg <= `JTI_IR_CAPTURE;
        end else if (state_reg == JTI_CAP_IR) begin
            ir_shift_reg <= `JTI_IR_CAPTURE;
        end else if (state_reg == JTI_SH_IR) begin
            ir_shift_reg <= {tdi, ir_shift_reg[`JTI_IR_W-1:1]};
        end
    end

    // Active instruction, defaults to identification
    always_ff @(posedge tck or posedge tap_arst) begin
        if (tap_arst) begin
            ir_reg <= `JTI_IR_IDCODE;
        end else if (state_reg == JTI_TLR) begin
            ir_reg <= `JTI_IR_IDCODE;
        end else if (state_reg == JTI_UPD_IR) begin
            ir_reg <= ir_shift_reg;
        end
    end

    // Instruction decode
    always_comb begin
        unique case (ir_reg)
            `JTI_IR_EXTEST, `JTI_IR_INTEST, `JTI_IR_SAMPLE: dr_sel = JTI_DR_BSR;
            `JTI_IR_ABORT:  dr_sel = JTI_DR_ABORT;
            `JTI_IR_DBG_PORT: dr_sel = JTI_DR_DP;
            `JTI_IR_ACC_PORT: dr_sel = JTI_DR_AP;
            `JTI_IR_IDCODE: dr_sel = JTI_DR_ID;
            default:        dr_sel = JTI_DR_BYP;
        endcase
    end

    // Boundary mode levels set at instruction update; test clock may stop right after it
    always_ff @(posedge tck or posedge tap_arst) begin
        if (tap_arst) begin
            extest_reg <= 1'b0;
            intest_reg <= 1'b0;
        end else if (state_next == JTI_TLR || state_reg == JTI_UPD_IR) begin
            extest_reg <= (state_next != JTI_TLR) && (ir_shift_reg == `JTI_IR_EXTEST);
            intest_reg <= (state_next != JTI_TLR) && (ir_shift_reg == `JTI_IR_INTEST);
        end
    end

    // Boundary chain: capture, shift, update
    always_ff @(posedge tck or posedge tap_arst) begin
        if (tap_arst) begin
            bsr_shift_reg <= '0;
            bsr_upd_reg   <= '0;
        end else if (dr_sel == JTI_DR_BSR) begin
            if (state_reg == JTI_CAP_DR) begin
                bsr_shift_reg <= sample_t;
            end else if (state_reg == JTI_SH_DR) begin
                bsr_shift_reg <= {tdi, bsr_shift_reg[BSR_W-1:1]};
            end else if (state_reg == JTI_UPD_DR) begin
                bsr_upd_reg <= bsr_shift_reg;
            end
        end
    end

    // Identification and bypass chains
    always_ff @(posedge tck or posedge tap_arst) begin
        if (tap_arst) begin
            id_shift_reg <= '0;
            byp_reg      <= 1'b0;
        end else if (state_reg == JTI_CAP_DR) begin
            id_shift_reg <= {ID_CODE[`JTI_ID_W-1:1], 1'b1};
            byp_reg      <= `JTI_BYP_CAPTURE;
        end else if (state_reg == JTI_SH_DR) begin
            id_shift_reg <= {tdi, id_shift_reg[`JTI_ID_W-1:1]};
            byp_reg      <= tdi;
        end
    end

    // Shared 35-bit chain for abort, debug-port and access-port access
    always_ff @(posedge tck or posedge tap_arst) begin
        if (tap_arst) begin
            acc_shift_reg <= '0;
            acc_wd_reg    <= '0;
            acc_sel_reg   <= JTI_ACC_ABORT;
            acc_tgl_reg   <= 1'b0;
        end else if (dr_sel == JTI_DR_ABORT || dr_sel == JTI_DR_DP || dr_sel == JTI_DR_AP) begin
            if (state_reg == JTI_CAP_DR) begin
                acc_shift_reg <= (dr_sel == JTI_DR_ABORT) ? '0 : rdata_t;
            end else if (state_reg == JTI_SH_DR) begin
                acc_shift_reg <= {tdi, acc_shift_reg[`JTI_ACC_W-1:1]};
            end else if (state_reg == JTI_UPD_DR) begin
                acc_wd_reg  <= acc_shift_reg;
                acc_sel_reg <= (dr_sel == JTI_DR_ABORT) ? JTI_ACC_ABORT :
                               (dr_sel == JTI_DR_DP) ? JTI_ACC_DP : JTI_ACC_AP;
                acc_tgl_reg <= ~acc_tgl_reg;
            end
        end
    end

    // TDO launched on falling TCK, driven only while shifting
    always_ff @(negedge tck or posedge tap_arst) begin
        if (tap_arst) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else begin
            tdo_oe <= (state_reg == JTI_SH_IR) || (state_reg == JTI_SH_DR);
            if (state_reg == JTI_SH_IR) begin
                tdo <= ir_shift_reg[0];
            end else begin
                unique case (dr_sel)
                    JTI_DR_BSR: tdo <= bsr_shift_reg[0];
                    JTI_DR_ID:  tdo <= id_shift_reg[0];
                    JTI_DR_BYP: tdo <= byp_reg;
                    default:    tdo <= acc_shift_reg[0];
                endcase
            end
        end
    end

    // Crossings into the test clock domain
    jti_sync #(.W(BSR_W)) u_sample_sync (.clk(tck), .arst(tap_arst), .d(sample_reg), .q(sample_t));
    jti_sync #(.W(`JTI_ACC_W)) u_rdata_sync (.clk(tck), .arst(tap_arst), .d(rdata_reg), .q(rdata_t));

    // Crossings into the system clock domain
    jti_sync #(.W(BSR_W + 3)) u_mode_sync (.clk(clock), .arst(rst),
        .d({bsr_upd_reg, extest_reg, intest_reg, acc_tgl_reg}), .q({bsr_upd_s, extest_s, intest_s, acc_tgl_s}));
    jti_sync #(.W(NPIN + 1)) u_pad_sync (.clk(clock), .arst(rst),
        .d({pad_in, ext_rst_n_pad}), .q({pad_in_s, ext_rst_s}));

    // Cell positions: per pin input, output, enable; reset cell last
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_cell
            assign upd_in[gi]  = bsr_upd_s[`JTI_CELLS_PER_PIN*gi + `JTI_CELL_IN];
            assign upd_out[gi] = bsr_upd_s[`JTI_CELLS_PER_PIN*gi + `JTI_CELL_OUT];
            assign upd_oe[gi]  = bsr_upd_s[`JTI_CELLS_PER_PIN*gi + `JTI_CELL_OE];
        end
    endgenerate

    // Pad and core muxing under boundary modes
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pad_out        <= '0;
            pad_oe         <= '0;
            core_in        <= '0;
            core_ext_rst_n <= 1'b0;
        end else begin
            pad_out        <= extest_s ? upd_out : core_out;
            pad_oe         <= extest_s ? upd_oe : core_oe;
            core_in        <= intest_s ? upd_in : pad_in_s;
            core_ext_rst_n <= ext_rst_s;
        end
    end

    // Pad sample vector in chain order
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sample_reg <= '0;
        end else begin
            for (int i = 0; i < NPIN; i++) begin
                sample_reg[`JTI_CELLS_PER_PIN*i + `JTI_CELL_IN]  <= pad_in_s[i];
                sample_reg[`JTI_CELLS_PER_PIN*i + `JTI_CELL_OUT] <= pad_out[i];
                sample_reg[`JTI_CELLS_PER_PIN*i + `JTI_CELL_OE]  <= pad_oe[i];
            end
            sample_reg[BSR_W-1] <= ext_rst_s;
        end
    end

    // Debug request hand-off: toggle edge becomes one-cycle pulses
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            acc_tgl_d_reg  <= 1'b0;
            dbg_req        <= 1'b0;
            dbg_sel        <= JTI_ACC_ABORT;
            dbg_wdata      <= '0;
            dbg_abort      <= 1'b0;
            dbg_clr_sticky <= 1'b0;
            rdata_reg      <= '0;
        end else begin
            acc_tgl_d_reg  <= acc_tgl_s;
            dbg_req        <= (acc_tgl_s != acc_tgl_d_reg) && (acc_sel_reg != JTI_ACC_ABORT);
            dbg_abort      <= (acc_tgl_s != acc_tgl_d_reg) && (acc_sel_reg == JTI_ACC_ABORT)
                              && acc_wd_reg[`JTI_ABORT_BIT];
            dbg_clr_sticky <= (acc_tgl_s != acc_tgl_d_reg) && (acc_sel_reg == JTI_ACC_ABORT)
                              && (|acc_wd_reg[`JTI_STICKY_HI:`JTI_STICKY_LO]);
            if (acc_tgl_s != acc_tgl_d_reg) begin
                dbg_sel   <= acc_sel_reg;
                dbg_wdata <= acc_wd_reg;
            end
            rdata_reg      <= dbg_rdata;
        end
    end

    // Checks in the test clock domain
    chk_ir_reset_id: assert property (@(posedge tck) disable iff (tap_arst)
        state_reg == JTI_TLR |=> ir_reg == `JTI_IR_IDCODE)
        else $error("instruction not identification after test logic reset");
    chk_ir_update_only: assert property (@(posedge tck) disable iff (tap_arst)
        (state_reg != JTI_UPD_IR && state_reg != JTI_TLR) |=> $stable(ir_reg))
        else $error("instruction changed outside update");
    chk_id_lsb_one: assert property (@(posedge tck) disable iff (tap_arst)
        (state_reg == JTI_CAP_DR && dr_sel == JTI_DR_ID) |=> id_shift_reg == {ID_CODE[31:1], 1'b1})
        else $error("identification capture wrong");
    chk_byp_capture: assert property (@(posedge tck) disable iff (tap_arst)
        (state_reg == JTI_CAP_DR && dr_sel == JTI_DR_BYP) |=> byp_reg == 1'b0)
        else $error("bypass did not capture zero");
    chk_unused_bypass: assert property (@(posedge tck) disable iff (tap_arst)
        !(ir_reg inside {4'h0, 4'h1, 4'h2, 4'h8, 4'hA, 4'hB, 4'hE}) |-> dr_sel == JTI_DR_BYP)
        else $error("unassigned code not bypass");
    chk_bsr_update: assert property (@(posedge tck) disable iff (tap_arst)
        (state_reg == JTI_UPD_DR && dr_sel == JTI_DR_BSR) |=> bsr_upd_reg == $past(bsr_shift_reg))
        else $error("boundary holding register not updated");
    chk_acc_shift: assert property (@(posedge tck) disable iff (tap_arst)
        (state_reg == JTI_SH_DR && dr_sel == JTI_DR_DP) |=> acc_shift_reg[34] == $past(tdi))
        else $error("access chain length wrong");

    // Checks in the system clock domain
    chk_extest_drive: assert property (@(posedge clock) disable iff (rst)
        extest_s |=> pad_out == $past(upd_out) && pad_oe == $past(upd_oe))
        else $error("pads not driven from boundary cells");
    chk_intest_drive: assert property (@(posedge clock) disable iff (rst)
        intest_s |=> core_in == $past(upd_in))
        else $error("core inputs not driven from boundary cells");
    chk_rst_observe: assert property (@(posedge clock) disable iff (rst)
        1'b1 |=> core_ext_rst_n == $past(ext_rst_s))
        else $error("reset cell overrode reset pin");
endmodule // jti_tap_regs

// *** verif/jti_tester.sv ***
// Behavioural boundary-scan tester that steps the test port from outside
module jti_tester (
    // Test port pins
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      trst_n,
    input  wire logic tdo,
    input  wire logic tdo_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    logic tdo_seen;
    logic oe_seen;
    logic oe_ok;

    // Test clock stands low between frames
    initial begin
        tck = 1'h0;
        tms = 1'h1;
        tdi = 1'h1;
        trst_n = 1'h1;
    end

    // One 12 ns test clock period; inputs set while low, tdo taken at rise
    task automatic tick(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #6;
        tck = 1'h1;
        q = tdo;
        oe_seen = tdo_oe;
        #6;
        tck = 1'h0;
    endtask

    // Walk to Test-Logic-Reset, then settle in Run-Test/Idle
    task automatic to_idle();
        for (int i = 0; i < 5; i++) begin
            tick(1'h1, ~tdi, tdo_seen);
        end
        tick(1'h0, ~tdi, tdo_seen);
    endtask

    // Scan of n bits LSB first, Run-Test/Idle back to Run-Test/Idle
    task automatic scan(input bit ir, input int n, input logic [63:0] din, output logic [63:0] dout);
        dout = '0;
        oe_ok = 1'h1;
        tick(1'h1, ~tdi, tdo_seen);
        if (ir) begin
            tick(1'h1, ~tdi, tdo_seen);
        end
        tick(1'h0, ~tdi, tdo_seen);
        tick(1'h0, ~tdi, tdo_seen);
        for (int k = 0; k < n; k++) begin
            tick(k == n - 1, din[k], dout[k]);
            oe_ok = oe_ok & oe_seen;
        end
        tick(1'h1, ~tdi, tdo_seen);
        tick(1'h0, ~tdi, tdo_seen);
        oe_ok = oe_ok & ~oe_seen;
    endtask

    // Asynchronous test reset pulse
    task automatic test_reset();
        trst_n = 1'h0;
        #20;
        trst_n = 1'h1;
    endtask
endmodule // jti_tester

// *** verif/tb.sv ***
// Self-checking bench of the test access port instruction and data chains
`include "jti_map.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import jti_pkg::*;

    localparam int          NPIN = 8;
    localparam int          BSL  = 3 * NPIN + 1;
    localparam logic [31:0] ID   = 32'h1357_9BDF; // Arbitrary identification value

    logic clock, rst, tck, tms, tdi, trst_n, tdo, tdo_oe, ext_rst_n_pad, core_ext_rst_n;
    logic [NPIN-1:0]       pad_in, pad_out, pad_oe, core_out, core_oe, core_in, eo, ee, ei;
    logic                  dbg_req, dbg_abort, dbg_clr_sticky;
    jti_acc_t              dbg_sel, last_sel;
    logic [`JTI_ACC_W-1:0] dbg_wdata, dbg_rdata, last_wdata, w;
    logic [63:0]           so, pre;
    logic [3:0]            codes[$] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hC, 4'hD, 4'hF};
    int err_count = 0, check_count = 0, req_count = 0, abort_count = 0, clr_count = 0, cycles = 0;

    jti_tap_regs #(.NPIN(NPIN), .ID_CODE(ID)) jti_tap_regs_inst (
        .clock(clock), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
        .tdo_oe(tdo_oe), .pad_in(pad_in), .ext_rst_n_pad(ext_rst_n_pad), .pad_out(pad_out),
        .pad_oe(pad_oe), .core_out(core_out), .core_oe(core_oe), .core_in(core_in),
        .core_ext_rst_n(core_ext_rst_n), .dbg_req(dbg_req), .dbg_sel(dbg_sel), .dbg_wdata(dbg_wdata),
        .dbg_abort(dbg_abort), .dbg_clr_sticky(dbg_clr_sticky), .dbg_rdata(dbg_rdata)
    );
    jti_tester jti_tester_inst (
        .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe)
    );

    // System clock, 50 ns period
    always #25 clock = ~clock;

    // Count debug pulses and keep the word handed over
    always @(posedge clock) begin
        cycles++;
        if (dbg_req === 1'h1) begin
            req_count++;
            last_sel = dbg_sel;
            last_wdata = dbg_wdata;
        end
        if (dbg_abort === 1'h1) abort_count++;
        if (dbg_clr_sticky === 1'h1) clr_count++;
        if (cycles == 20000) begin
            err_count++;
            conclude();
        end
    end

    // Compare and count
    task automatic chk(input string name, input logic [63:0] e, input logic [63:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask

    // Verdict and end of run
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Model of a boundary capture: per pin input, output, enable, then reset pin
    function automatic logic [63:0] bsr_model();
        logic [63:0] v;
        v = '0;
        for (int i = 0; i < NPIN; i++) begin
            v[3*i] = pad_in[i];
            v[3*i+1] = core_out[i];
            v[3*i+2] = core_oe[i];
        end
        v[3*NPIN] = ext_rst_n_pad;
        return v;
    endfunction

    // Main sequence
    initial begin
        clock = 1'h0;
        rst = 1'h1;
        pad_in = '0;
        ext_rst_n_pad = 1'h1;
        core_out = '0;
        core_oe = '0;
        dbg_rdata = '0;
        void'($urandom(27));
        repeat (5) @(posedge clock);
        @(negedge clock) rst = 1'h0;
        repeat (5) @(negedge clock);
        jti_tester_inst.to_idle();
        jti_tester_inst.scan(0, 32, 64'h0, so);
        chk("idcode", ID, so);
        chk("tdo_oe", 1'h1, jti_tester_inst.oe_ok);
        // Every spare code and the bypass code give a one-bit path capturing 0
        foreach (codes[j]) begin
            jti_tester_inst.scan(1, 4, codes[j], so);
            chk("ir_capture", 64'h1, so);
            pre = {$urandom, $urandom};
            jti_tester_inst.scan(0, 8, pre, so);
            chk("bypass", {pre[6:0], 1'h0}, so);
        end
        // Sample pads and preload the chain
        @(negedge clock);
        pad_in = NPIN'($urandom);
        core_out = NPIN'($urandom);
        core_oe = NPIN'($urandom);
        repeat (8) @(negedge clock);
        jti_tester_inst.scan(1, 4, 64'h2, so);
        pre = {$urandom, $urandom};
        pre[3*NPIN] = ~ext_rst_n_pad;
        jti_tester_inst.scan(0, BSL, pre, so);
        chk("sample", bsr_model(), so);
        for (int i = 0; i < NPIN; i++) begin
            ei[i] = pre[3*i];
            eo[i] = pre[3*i+1];
            ee[i] = pre[3*i+2];
        end
        // Preloaded cells drive the pads
        jti_tester_inst.scan(1, 4, 64'h0, so);
        repeat (8) @(negedge clock);
        chk("pad_out", eo, pad_out);
        chk("pad_oe", ee, pad_oe);
        // Preloaded cells drive the core, the reset pin stays observed only
        jti_tester_inst.scan(1, 4, 64'h1, so);
        repeat (8) @(negedge clock);
        chk("core_in", ei, core_in);
        chk("pad_out_core", core_out, pad_out);
        chk("core_rst", ext_rst_n_pad, core_ext_rst_n);
        ext_rst_n_pad = 1'h0;
        repeat (8) @(negedge clock);
        chk("core_rst_low", 1'h0, core_ext_rst_n);
        chk("core_in_hold", ei, core_in);
        ext_rst_n_pad = 1'h1;
        // Test-Logic-Reset drops overrides and restores identification
        jti_tester_inst.to_idle();
        repeat (8) @(negedge clock);
        chk("core_in_tlr", pad_in, core_in);
        jti_tester_inst.scan(0, 32, 64'h0, so);
        chk("idcode_tlr", ID, so);
        @(negedge clock);
        // Debug-port then access-port word
        for (int j = 0; j < 2; j++) begin
            dbg_rdata = `JTI_ACC_W'({$urandom, $urandom});
            w = `JTI_ACC_W'({$urandom, $urandom});
            repeat (4) @(negedge clock);
            jti_tester_inst.scan(1, 4, (j == 1) ? 64'hB : 64'hA, so);
            jti_tester_inst.scan(0, `JTI_ACC_W, w, so);
            repeat (10) @(negedge clock);
            chk("dbg_rdata", dbg_rdata, so);
            chk("dbg_req", j + 1, req_count);
            chk("dbg_sel", (j == 1) ? JTI_ACC_AP : JTI_ACC_DP, last_sel);
            chk("dbg_wdata", w, last_wdata);
        end
        // Abort chain: abort bit, then a sticky clear bit
        jti_tester_inst.scan(1, 4, 64'h8, so);
        jti_tester_inst.scan(0, `JTI_ACC_W, 64'h8, so);
        chk("abort_cap", 64'h0, so);
        jti_tester_inst.scan(0, `JTI_ACC_W, 64'h40, so);
        repeat (10) @(negedge clock);
        chk("abort", 1, abort_count);
        chk("clr_sticky", 1, clr_count);
        chk("req_after_abort", 2, req_count);
        // Test reset reloads identification
        jti_tester_inst.scan(1, 4, 64'hF, so);
        jti_tester_inst.test_reset();
        jti_tester_inst.tick(1'h0, 1'h0, so[0]);
        jti_tester_inst.scan(0, 32, 64'h0, so);
        chk("idcode_trst", ID, so);
        chk("tdo_oe_trst", 1'h1, jti_tester_inst.oe_ok);
        conclude();
    end
endmodule // tb
